// ### rcs_core.sv
// Remote command sequencer: parser sequencing, staging, sync and APB registers
//
// Function
// - Commands run in order; clear first
// - Parsed settings go to shadow store only
// - Syntax error reported, parsing continues
// - Line end requests transfer, stalls intake until checked
// - Hardware updated only at line end
// - Incompatible set: execution error, discard staging
// - Only final line state is checked
// - Settling flag set before apply, cleared settled
// - Queries fill output buffer in portions
// - Talk with nothing pending: query error
// - Operation complete flag after settling
// - Completion query answers one after settling
// - Wait holds next command until settled
// - Status byte summarises lower registers
// - Individual status flag masked by poll enable
// - Message available follows output buffer
// - Device clear flushes input, notifies parser
// - Enabled status rise raises service request
`timescale 1ns/10ps
module rcs_core
	import rcs_pkg::*;
#(
	parameter int OB_DEPTH = 4,
	parameter int EQ_DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire rcs_cmd_t cmd_code,
	input wire logic [1:0] cmd_idx,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	input wire logic dcl_pin,
	output logic in_flush,
	input wire logic hw_settled_pin,
	input wire logic ques_pin,
	output logic hw_apply,
	output logic [31:0] hw_set,
	output logic trig,
	input wire logic talk_en,
	output logic out_valid,
	output logic [7:0] out_data,
	input wire logic out_ready,
	output logic srq,
	output logic ist
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		rcs_st_t st;
		logic [1:0] qi;
		logic [31:0] stage;
		logic [31:0] appl;
		logic [31:0] hset;
		logic [31:0] ill;
		logic [7:0] ese;
		logic [7:0] sre;
		logic [7:0] ppe;
		logic [2:0] sy0;
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [2:0] lvl;
		logic xreq;
		logic papl;
		logic settl;
		logic opcp;
		logic talkp;
		logic flush;
		logic apl;
		logic trg;
		logic crdy;
		logic ov;
		logic [7:0] od;
		logic [31:0] rd;
		logic rdy;
		logic err;
	} rcs_core_t;

	rcs_core_t q, n;
	rcs_stat_if sif();
	rcs_ob_if obf();
	logic take, busy, setup, wr_acc, rd_acc, dcl_rise, set_rise, bad, hit;
	logic talk_rise, resp_due, hold;

	// ----------------------------------------
	// Units
	// ----------------------------------------
	// Status byte, event register, request flags and error queue
	rcs_status #(.EQ_DEPTH(EQ_DEPTH)) u_status (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.st(sif.stat)
	);

	// Response bytes waiting for the talker
	rcs_outbuf #(.DEPTH(OB_DEPTH)) u_outbuf (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.ob(obf.buf_side)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		sif.ev_opc = 1'b0;
		sif.ev_qye = 1'b0;
		sif.ev_exe = 1'b0;
		sif.ev_cme = 1'b0;
		sif.esr_rd = 1'b0;
		sif.eq_pop = 1'b0;
		obf.push = 1'b0;
		obf.pop = 1'b0;
		obf.wdata = ASCII_ONE;
		n.flush = 1'b0;
		n.apl = 1'b0;
		n.trg = 1'b0;
		hit = 1'b1;

		// ----------------------------------------
		// Pin synchronisers: a change counts once stages two and three agree
		// ----------------------------------------
		n.sy0 = {ques_pin, hw_settled_pin, dcl_pin};
		n.sy1 = q.sy0;
		n.sy2 = q.sy1;
		n.lvl = (q.sy1 & q.sy2) | (q.lvl & (q.sy1 ^ q.sy2));
		dcl_rise = n.lvl[P_DCL] && !q.lvl[P_DCL];
		set_rise = n.lvl[P_SET] && !q.lvl[P_SET];

		busy = q.settl || q.xreq || q.papl;
		take = cmd_valid && q.crdy;

		// ----------------------------------------
		// Command intake, strictly in arrival order
		// ----------------------------------------
		if (take) begin
			unique case (cmd_code)
				C_SET: n.stage[{cmd_idx, 3'b000} +: 8] = cmd_data;
				C_QRY: begin
					n.st = ST_QRY;
					n.qi = 2'b00;
				end
				C_OPC: n.opcp = 1'b1;
				C_OPCQ: n.st = ST_OPCQ;
				C_WAI: n.st = ST_WAI;
				C_GET: n.trg = 1'b1;
				C_EOL: n.xreq = 1'b1;
				C_SYN: sif.ev_cme = 1'b1;
			endcase
		end

		// ----------------------------------------
		// Device clear: flush input unit and close the line at once
		// ----------------------------------------
		if (dcl_rise) begin
			n.flush = 1'b1;
			n.xreq = 1'b1;
		end

		// ----------------------------------------
		// Check the staged set just before transfer
		// ----------------------------------------
		// Settling ends first, so a passing check in the same cycle raises it again
		if (set_rise && q.settl && !q.papl) n.settl = 1'b0;
		if (q.xreq) begin
			n.xreq = dcl_rise;
			bad = (q.ill != '0) && ((q.stage & q.ill) == q.ill);
			if (bad) begin
				sif.ev_exe = 1'b1;
				n.stage = q.appl;
			end else begin
				n.settl = 1'b1;
				n.papl = 1'b1;
				n.appl = q.stage;
			end
		end else begin
			bad = 1'b0;
		end

		// ----------------------------------------
		// Apply one cycle after settling was raised
		// ----------------------------------------
		if (q.papl) begin
			n.papl = 1'b0;
			n.apl = 1'b1;
			n.hset = q.appl;
		end

		// ----------------------------------------
		// Operation complete once everything has settled
		// ----------------------------------------
		if (q.opcp && !busy) begin
			sif.ev_opc = 1'b1;
			n.opcp = 1'b0;
		end

		// ----------------------------------------
		// Held commands and query output
		// ----------------------------------------
		unique case (q.st)
			ST_RUN: ;
			ST_QRY: begin
				obf.wdata = q.appl[{q.qi, 3'b000} +: 8];
				if (!obf.full) begin
					obf.push = 1'b1;
					n.qi = q.qi + 2'b01;
					if (q.qi == 2'b11) n.st = ST_RUN;
				end
			end
			ST_OPCQ: begin
				if (!busy && !obf.full) begin
					obf.push = 1'b1;
					n.st = ST_RUN;
				end
			end
			ST_WAI: begin
				if (!busy) n.st = ST_RUN;
			end
		endcase

		// ----------------------------------------
		// Output unit: hand bytes to the talker while addressed
		// ----------------------------------------
		if (talk_en && (!q.ov || out_ready) && !obf.empty) begin
			obf.pop = 1'b1;
			n.ov = 1'b1;
			n.od = obf.head;
		end else if (out_ready) begin
			n.ov = 1'b0;
		end
		n.talkp = talk_en;
		talk_rise = talk_en && !q.talkp;
		// A running query or completion query still owes the talker a reply
		resp_due = !obf.empty || q.ov || (q.st == ST_QRY) || (q.st == ST_OPCQ);
		if (talk_rise && !resp_due) begin
			sif.ev_qye = 1'b1;
		end

		// ----------------------------------------
		// APB slave
		// ----------------------------------------
		setup = psel && !penable;
		wr_acc = psel && penable && q.rdy && pwrite;
		rd_acc = psel && penable && q.rdy && !pwrite;
		n.rdy = setup;
		n.err = 1'b0;
		// Read data is captured in the setup cycle so it stands with pready
		if (setup) begin
			n.rd = '0;
			unique case (paddr)
				A_STAGE: n.rd = q.stage;
				A_APPL: n.rd = q.appl;
				A_ILL: n.rd = q.ill;
				A_ESR: n.rd[7:0] = sif.esr;
				A_ESE: n.rd[7:0] = q.ese;
				A_SRE: n.rd[7:0] = q.sre;
				A_PPE: n.rd[7:0] = q.ppe;
				A_STB: n.rd[7:0] = sif.stb;
				A_OPER: n.rd[O_SETTLE] = q.settl;
				A_ERRQ: n.rd[15:0] = sif.eq_data;
				default: hit = 1'b0;
			endcase
			n.err = !hit;
		end
		if (wr_acc) begin
			unique case (paddr)
				A_ILL: n.ill = pwdata;
				A_ESE: n.ese = pwdata[7:0];
				A_SRE: n.sre = pwdata[7:0];
				A_PPE: n.ppe = pwdata[7:0];
				default: ;
			endcase
		end
		// Read side effects act once, at the access edge
		if (rd_acc && paddr == A_ESR) sif.esr_rd = 1'b1;
		if (rd_acc && paddr == A_ERRQ) sif.eq_pop = 1'b1;

		// ----------------------------------------
		// Parser stalls during checks, held commands and clears
		// ----------------------------------------
		// Commands that leave a job behind drop ready for one cycle at least
		hold = take && (cmd_code != C_SET) && (cmd_code != C_SYN) && (cmd_code != C_GET);
		n.crdy = (n.st == ST_RUN) && !n.xreq && !hold;
	end

	// ----------------------------------------
	// Status links
	// ----------------------------------------
	assign sif.ese = q.ese;
	assign sif.sre = q.sre;
	assign sif.ppe = q.ppe;
	assign sif.mav = !obf.empty || q.ov;
	assign sif.oper = q.settl;
	assign sif.ques = q.lvl[P_QUES];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// A low clock enable freezes every field; the units use the same enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ill <= ILL_RST;
		end else if (ce) begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = q.rd;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign cmd_ready = q.crdy;
	assign in_flush = q.flush;
	assign hw_apply = q.apl;
	assign hw_set = q.hset;
	assign trig = q.trg;
	assign out_valid = q.ov;
	assign out_data = q.od;
	assign srq = sif.srq;
	assign ist = sif.ist;
endmodule

// ### rcs_core_assertions.sv
// Concurrent checks on the command sequencer ports
`timescale 1ns/10ps
module rcs_core_assertions
	import rcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic cmd_valid,
	input wire rcs_cmd_t cmd_code,
	input wire logic cmd_ready,
	input wire logic dcl_pin,
	input wire logic in_flush,
	input wire logic hw_apply,
	input wire logic [31:0] hw_set
);
	logic tk;
	assign tk = cmd_valid && cmd_ready && ce;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_wait: assert property (psel && !penable && ce |=> pready)
		else $error("pready missing after setup");
	chk_apb_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_hw_hold: assert property ($changed(hw_set) |-> hw_apply)
		else $error("hw_set moved without apply");
	chk_set_keeps: assert property (tk && cmd_code == C_SET |=> cmd_ready)
		else $error("setting stalled intake");
	chk_qry_stall: assert property (tk && cmd_code == C_QRY |=> !cmd_ready)
		else $error("query did not stall intake");
	chk_wai_hold: assert property (tk && cmd_code == C_WAI |=> !cmd_ready)
		else $error("wait did not hold intake");
	chk_eol_resume: assert property (tk && cmd_code == C_EOL |=> !cmd_ready ##[1:4] cmd_ready)
		else $error("line end intake wrong");
	chk_flush_seen: assert property ($rose(dcl_pin) |-> ##[2:8] in_flush)
		else $error("no flush after clear");
	chk_flush_pulse: assert property (in_flush |=> !in_flush)
		else $error("flush longer than one cycle");
endmodule
bind rcs_core rcs_core_assertions u_chk (.pclk, .presetn, .ce, .psel, .penable, .pready,
	.cmd_valid, .cmd_code, .cmd_ready, .dcl_pin, .in_flush, .hw_apply, .hw_set);

// ### rcs_hw_model.sv
// Hardware side: settles a set number of cycles after each apply
`timescale 1ns/10ps
module rcs_hw_model (
	input wire logic pclk,
	input wire logic hw_apply,
	input wire logic [3:0] dly,
	output logic hw_settled_pin
);
	logic [3:0] n = 4'h0;
	initial hw_settled_pin = 1'b1;
	always @(posedge pclk) begin
		if (hw_apply) begin
			hw_settled_pin <= 1'b0;
			n <= dly;
		end else if (n != 4'h0)
			n <= n - 4'h1;
		else
			hw_settled_pin <= 1'b1;
	end
endmodule

// ### rcs_if.sv
// Links between the sequencer core and its status and output buffer units
`timescale 1ns/10ps
interface rcs_stat_if;
	logic ev_opc, ev_qye, ev_exe, ev_cme, mav, oper, ques, esr_rd, eq_pop;
	logic [7:0] ese, sre, ppe, esr, stb;
	logic [15:0] eq_data;
	logic srq, ist;
	modport core(output ev_opc, ev_qye, ev_exe, ev_cme, mav, oper, ques, esr_rd,
		eq_pop, ese, sre, ppe, input esr, stb, eq_data, srq, ist);
	modport stat(input ev_opc, ev_qye, ev_exe, ev_cme, mav, oper, ques, esr_rd,
		eq_pop, ese, sre, ppe, output esr, stb, eq_data, srq, ist);
endinterface

interface rcs_ob_if;
	logic push, pop, full, empty;
	logic [7:0] wdata, head;
	modport core(output push, pop, wdata, input full, empty, head);
	modport buf_side(input push, pop, wdata, output full, empty, head);
endinterface

// ### rcs_outbuf.sv
// Response byte buffer of the output unit
`timescale 1ns/10ps
module rcs_outbuf
	import rcs_pkg::*;
#(
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	rcs_ob_if.buf_side ob
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	typedef struct packed {
		logic [PW-1:0] rp;
		logic [PW-1:0] wp;
		logic [CW-1:0] cnt;
	} rcs_ob_t;
	rcs_ob_t q, n;
	logic [7:0] mem [DEPTH];
	logic wr, rd;

	// DEPTH must be a power of two so the pointers wrap by themselves
	assign wr = ob.push && (q.cnt != FULL_CNT);
	assign rd = ob.pop && (q.cnt != '0);
	assign ob.full = (q.cnt == FULL_CNT);
	assign ob.empty = (q.cnt == '0);
	assign ob.head = mem[q.rp];

	always_comb begin
		n = q;
		if (wr) n.wp = q.wp + 1'b1;
		if (rd) n.rp = q.rp + 1'b1;
		n.cnt = q.cnt + CW'(wr) - CW'(rd);
	end

	always_ff @(posedge pclk) begin
		if (ce && wr) mem[q.wp] <= ob.wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) q <= '0;
		else if (ce) q <= n;
	end
endmodule

// ### rcs_pkg.sv
// Constants and types shared by the remote command sequencer
package rcs_pkg;
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	localparam int AW = 8;
	localparam logic [AW-1:0] A_STAGE = 8'h00;
	localparam logic [AW-1:0] A_APPL = 8'h04;
	localparam logic [AW-1:0] A_ILL = 8'h08;
	localparam logic [AW-1:0] A_ESR = 8'h0c;
	localparam logic [AW-1:0] A_ESE = 8'h10;
	localparam logic [AW-1:0] A_SRE = 8'h14;
	localparam logic [AW-1:0] A_PPE = 8'h18;
	localparam logic [AW-1:0] A_STB = 8'h1c;
	localparam logic [AW-1:0] A_OPER = 8'h20;
	localparam logic [AW-1:0] A_ERRQ = 8'h24;
	localparam logic [31:0] ILL_RST = 32'h0000_0000;
	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int E_OPC = 0;
	localparam int E_QYE = 2;
	localparam int E_EXE = 4;
	localparam int E_CME = 5;
	localparam int S_EAV = 2;
	localparam int S_QUES = 3;
	localparam int S_MAV = 4;
	localparam int S_ESB = 5;
	localparam int S_MSS = 6;
	localparam int S_OPER = 7;
	localparam int O_SETTLE = 1;
	// ----------------------------------------
	// Error queue codes and reply text
	// ----------------------------------------
	localparam logic [15:0] ERR_CME = 16'hff9c;
	localparam logic [15:0] ERR_EXE = 16'hff38;
	localparam logic [15:0] ERR_QYE = 16'hfe5c;
	localparam logic [7:0] ASCII_ONE = 8'h31;
	// Pin index in the synchroniser vector
	localparam int P_DCL = 0;
	localparam int P_SET = 1;
	localparam int P_QUES = 2;
	typedef enum logic [2:0] {
		C_SET, C_QRY, C_OPC, C_OPCQ, C_WAI, C_GET, C_EOL, C_SYN
	} rcs_cmd_t;
	typedef enum logic [1:0] {ST_RUN, ST_QRY, ST_OPCQ, ST_WAI} rcs_st_t;
endpackage

// ### rcs_status.sv
// Status byte, event register, request and poll flags, error queue
`timescale 1ns/10ps
module rcs_status
	import rcs_pkg::*;
#(
	parameter int EQ_DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	rcs_stat_if.stat st
);
	localparam int PW = $clog2(EQ_DEPTH);
	localparam int CW = $clog2(EQ_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(EQ_DEPTH);
	typedef struct packed {
		logic [7:0] esr;
		logic [7:0] en_prev;
		logic srq;
		logic ist;
		logic [PW-1:0] rp;
		logic [PW-1:0] wp;
		logic [CW-1:0] cnt;
	} rcs_sts_t;
	rcs_sts_t q, n;
	logic [15:0] mem [EQ_DEPTH];
	logic [15:0] code;
	logic push, pop;
	logic [7:0] stb, en, rise, set_bits;

	always_comb begin
		stb = '0;
		stb[S_EAV] = (q.cnt != '0);
		stb[S_QUES] = st.ques;
		stb[S_MAV] = st.mav;
		stb[S_ESB] = |(q.esr & st.ese);
		stb[S_OPER] = st.oper;
		en = stb & st.sre;
		en[S_MSS] = 1'b0;
		stb[S_MSS] = |en;
	end

	always_comb begin
		set_bits = '0;
		set_bits[E_OPC] = st.ev_opc;
		set_bits[E_QYE] = st.ev_qye;
		set_bits[E_EXE] = st.ev_exe;
		set_bits[E_CME] = st.ev_cme;
		push = st.ev_cme || st.ev_exe || st.ev_qye;
		code = st.ev_cme ? ERR_CME : (st.ev_exe ? ERR_EXE : ERR_QYE);
		pop = st.eq_pop && (q.cnt != '0);
		rise = en & ~q.en_prev;
		n = q;
		// A new event wins over a read-clear in the same cycle
		n.esr = (st.esr_rd ? 8'h00 : q.esr) | set_bits;
		n.en_prev = en;
		if (|rise) n.srq = 1'b1;
		else if (!stb[S_MSS]) n.srq = 1'b0;
		n.ist = |(stb & st.ppe);
		if (push && q.cnt != FULL_CNT) n.wp = q.wp + 1'b1;
		if (pop) n.rp = q.rp + 1'b1;
		n.cnt = q.cnt + CW'(push && q.cnt != FULL_CNT) - CW'(pop);
	end

	assign st.esr = q.esr;
	assign st.stb = stb;
	assign st.srq = q.srq;
	assign st.ist = q.ist;
	assign st.eq_data = (q.cnt != '0) ? mem[q.rp] : 16'h0000;

	always_ff @(posedge pclk) begin
		if (ce && push && q.cnt != FULL_CNT) mem[q.wp] <= code;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) q <= '0;
		else if (ce) q <= n;
	end
endmodule

// ### remote_command_sequencer_tb_top.sv
// Self-checking bench for the command sequencer core
`timescale 1ns/10ps
module remote_command_sequencer_tb_top;
	import rcs_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic cmd_valid = 1'b0, dcl_pin = 1'b0, ques_pin = 1'b0, talk_en = 1'b0, out_ready = 1'b0;
	logic [AW-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r, appl = 32'h0, prdata, hw_set;
	rcs_cmd_t cmd_code = C_SET;
	logic [1:0] cmd_idx = 2'h0;
	logic [7:0] cmd_data = 8'h00, out_data;
	logic [3:0] dly = 4'hc, evs;
	logic e, pready, pslverr, cmd_ready, in_flush, hw_settled_pin, hw_apply, trig;
	logic out_valid, srq, ist;
	logic [7:0] rx[$];
	int n_errors = 0, n_checks = 0, cyc = 0;
	assign evs = {srq, trig, in_flush, hw_apply};
	always #50 pclk = ~pclk;
	rcs_core uut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .cmd_valid, .cmd_code, .cmd_idx, .cmd_data, .cmd_ready, .dcl_pin,
		.in_flush, .hw_settled_pin, .ques_pin, .hw_apply, .hw_set, .trig, .talk_en,
		.out_valid, .out_data, .out_ready, .srq, .ist);
	rcs_hw_model hw (.pclk, .hw_apply, .dly, .hw_settled_pin);
	always @(posedge pclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			rx.push_back(out_data);
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [AW-1:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic cmd(input rcs_cmd_t c, input logic [1:0] i = 2'h0, input logic [7:0] d = 8'h00);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_idx <= i;
		cmd_data <= d;
		do
			@(posedge pclk);
		while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wt(input int b, input string n);
		int k;
		k = 0;
		do
			@(posedge pclk);
		while (evs[b] !== 1'b1 && ++k < 100);
		chk(n, {31'h0, evs[b]}, 32'h1);
	endtask
	task automatic t_regs();
		rd(A_ILL);
		chk("ill_reset", r, ILL_RST);
		rd(8'h40);
		chk("unmapped_err", {31'h0, e}, 32'h1);
		chk("unmapped_data", r, 32'h0);
		// A pin change made while the clock enable is low must not be seen yet
		ce <= 1'b0;
		ques_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		ce <= 1'b1;
		rd(A_STB);
		chk("ques_frozen", {31'h0, r[S_QUES]}, 32'h0);
		repeat (2) @(posedge pclk);
		rd(A_STB);
		chk("stb_ques", {31'h0, r[S_QUES]}, 32'h1);
		ques_pin <= 1'b0;
	endtask
	task automatic t_line();
		wr(A_ILL, 32'hff);
		cmd(C_SET, 2'h0, 8'hff);
		cmd(C_SET, 2'h1, 8'h5a);
		cmd(C_SET, 2'h0, 8'h11);
		cmd(C_SET, 2'h3, 8'hc3);
		chk("hw_early", hw_set, appl);
		cmd(C_EOL);
		wt(0, "apply");
		appl = 32'hc3005a11;
		chk("hw_line", hw_set, appl);
		rd(A_APPL);
		chk("appl_reg", r, appl);
		rd(A_OPER);
		chk("settling", {31'h0, r[O_SETTLE]}, 32'h1);
		cmd(C_SET, 2'h0, 8'hff);
		cmd(C_EOL);
		rd(A_STAGE);
		chk("stage_undo", r, appl);
		chk("hw_kept", hw_set, appl);
		rd(A_ESR);
		chk("esr_exe", r, 32'h1 << E_EXE);
		rd(A_ERRQ);
		chk("errq_exe", r, {16'h0, ERR_EXE});
		wr(A_ILL, 32'h0);
	endtask
	task automatic t_syn();
		cmd(C_SYN);
		cmd(C_SET, 2'h1, 8'h77);
		cmd(C_EOL);
		wt(0, "apply_syn");
		appl[15:8] = 8'h77;
		chk("hw_syn", hw_set, appl);
		rd(A_ESR);
		chk("esr_cme", r, 32'h1 << E_CME);
		rd(A_ERRQ);
		chk("errq_cme", r, {16'h0, ERR_CME});
		rd(A_ERRQ);
		chk("errq_empty", r, 32'h0);
	endtask
	task automatic t_qry();
		cmd(C_QRY);
		rd(A_STB);
		chk("mav_set", {31'h0, r[S_MAV]}, 32'h1);
		out_ready <= 1'b1;
		talk_en <= 1'b1;
		cmd(C_OPCQ);
		for (int k = 0; k < 60 && rx.size() < 5; k++)
			@(posedge pclk);
		talk_en <= 1'b0;
		for (int k = 0; k < 4; k++)
			chk("qry_byte", rx[k], appl[8*k+:8]);
		chk("opcq_byte", rx[4], ASCII_ONE);
		rd(A_STB);
		chk("mav_clear", {31'h0, r[S_MAV]}, 32'h0);
		talk_en <= 1'b1;
		repeat (6) @(posedge pclk);
		talk_en <= 1'b0;
		chk("rx_count", rx.size(), 32'h5);
		rd(A_ESR);
		chk("esr_qye", r, 32'h1 << E_QYE);
		rd(A_ERRQ);
		chk("errq_qye", r, {16'h0, ERR_QYE});
	endtask
	task automatic t_opc();
		dly <= 4'h1;
		wr(A_ESE, 32'h1);
		wr(A_SRE, 32'h1 << S_ESB);
		chk("srq_idle", {31'h0, srq}, 32'h0);
		cmd(C_SET, 2'h2, 8'h3c);
		cmd(C_EOL);
		cmd(C_WAI);
		cmd(C_OPC);
		rd(A_OPER);
		chk("wai_settled", {31'h0, r[O_SETTLE]}, 32'h0);
		wt(3, "srq");
		rd(A_STB);
		chk("stb_esb", {24'h0, r[7:0] & 8'h60}, 32'h60);
		wr(A_PPE, 32'h1 << S_ESB);
		@(posedge pclk);
		chk("ist", {31'h0, ist}, 32'h1);
		rd(A_SRE);
		chk("sre_back", r, 32'h1 << S_ESB);
		rd(A_ESR);
		chk("esr_opc", r, 32'h1);
		repeat (2) @(posedge pclk);
		chk("srq_clear", {31'h0, srq}, 32'h0);
		chk("ist_clear", {31'h0, ist}, 32'h0);
		// The trigger pulse stands while the intake task is still finishing
		fork
			cmd(C_GET);
			wt(2, "trig");
		join
		dcl_pin <= 1'b1;
		wt(1, "flush");
		dcl_pin <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_line();
		t_syn();
		t_qry();
		t_opc();
		complete_run();
	end
endmodule
